// [core/tax_core.sv]
module tax_core
   import tax_pkg::*;
#(
   parameter int PW = PTR_W
)(
   input  wire logic         CLOCK_IN,
   input  wire logic         RST_IN,
   // AXI4-Lite slave
   input  wire tax_axi_req_t AXI_REQ_IN,
   output tax_axi_rsp_t      AXI_RSP_OUT,
   // Program memory read port
   output logic [PW-2:0]     PM_WORD_ADDR_OUT,
   output logic              PM_RD_OUT,
   input  wire logic [15:0]  PM_WORD_IN,
   // Index base for indexed literal offset mode
   input  wire logic [11:0]  INDEX_BASE_IN,
   output logic              SKIP_ACTIVE_OUT
);
   // Instruction state
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_TBL2 = 4'b0010,
      ST_SKIP = 4'b0100,
      ST_SKIP2 = 4'b1000
   } tax_state_t;

   tax_state_t       state_reg;       // Execution state
   logic [15:0]      instr_reg;       // Instruction under execution
   logic             two_word_reg;    // Following instruction is two words
   logic [7:0]       accum_reg;       // Work register
   logic [PW-1:0]    ptr_reg;         // Table byte pointer
   logic [PW-1:0]    tbl_addr_reg;    // Address held for second cycle
   logic [7:0]       latch_reg;       // Table data latch
   logic [3:0]       bank_reg;        // Bank select pointer
   tax_flags_t       flags_reg;       // Negative and zero flags
   logic             ext_en_reg;      // Extended set enable
   logic [7:0]       hold_reg [HOLD_N];  // Write-holding registers
   logic             issue;           // New instruction accepted

   // AXI slave state
   logic             aw_got_reg;      // Write address held
   logic             w_got_reg;       // Write data held
   logic [7:0]       awaddr_reg;      // Held write address
   logic [31:0]      wdata_reg;       // Held write data
   logic             bvalid_reg;      // Write response pending
   logic [1:0]       bresp_reg;       // Write response code
   logic             rvalid_reg;      // Read response pending
   logic [31:0]      rdata_reg;       // Read data
   logic [1:0]       rresp_reg;       // Read response code
   logic             wr_fire;         // Both halves present this cycle
   logic             wr_hit;          // Write targets a mapped word

   // Decode of the instruction word held in wdata_reg, not instr_reg
   logic             is_tbl;          // Table read or write
   logic             is_tbl_wr;       // Table write
   logic             is_xorlit;       // Literal xor
   logic             is_xorfile;      // File xor
   logic             is_tstz;         // Test for zero and skip
   logic [PW-1:0]    acc_addr;        // Table access address
   logic [PW-1:0]    ptr_after;       // Pointer after update
   logic [11:0]      faddr;           // Resolved data address
   logic [7:0]       fdata;           // File register contents
   logic [7:0]       xres;            // Xor result
   logic             fwe;             // File write enable

   assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
   assign wr_hit  = awaddr_reg <= OFS_HOLD0 + 8'h1C;
   assign issue   = wr_fire && awaddr_reg == OFS_INSTR
                    && state_reg == ST_IDLE;

   // Decode from the fresh instruction word
   always_comb
   begin
      is_tbl     = wdata_reg[15:2] == OP_TBL_HI ||
                   wdata_reg[15:2] == (OP_TBL_HI | 14'h0001);
      is_tbl_wr  = wdata_reg[2];
      is_xorlit  = wdata_reg[15:8] == OP_XORLIT;
      is_xorfile = wdata_reg[15:10] == OP_XORFILE;
      is_tstz    = wdata_reg[15:9] == OP_TSTZ;
   end

   // Pointer mode arithmetic
   tax_ptr_step #(
      .W          (PW)
   ) u_step (
      .ptr_in     (ptr_reg),
      .mode_in    (wdata_reg[1:0]),
      .access_out (acc_addr),
      .final_out  (ptr_after)
   );

   // Access bank, banked, or indexed address forming
   always_comb
   begin
      if (wdata_reg[8])
         faddr = {bank_reg, wdata_reg[7:0]};
      else if (ext_en_reg && wdata_reg[7:0] <= IDX_LIMIT)
         faddr = INDEX_BASE_IN + {4'h0, wdata_reg[7:0]};
      else if (wdata_reg[7:0] < ACCESS_HI)
         faddr = {4'h0, wdata_reg[7:0]};
      else
         faddr = {4'hF, wdata_reg[7:0]};
   end

   assign xres = is_xorlit ? accum_reg ^ wdata_reg[7:0]
                           : accum_reg ^ fdata;
   assign fwe  = issue && is_xorfile && wdata_reg[9];

   tax_dmem #(
      .AW        (ADDR_W)
   ) u_dmem (
      .clk_in    (CLOCK_IN),
      .rst_in    (RST_IN),
      .raddr_in  (faddr),
      .rdata_out (fdata),
      .we_in     (fwe),
      .waddr_in  (faddr),
      .wdata_in  (xres)
   );

   // Instruction sequencing
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         state_reg       <= ST_IDLE;
         instr_reg       <= 16'h0000;
         tbl_addr_reg    <= PTR_RST;
         SKIP_ACTIVE_OUT <= 1'b0;
         PM_RD_OUT       <= 1'b0;
         PM_WORD_ADDR_OUT <= '0;
      end
      else
      begin
         PM_RD_OUT <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (issue && is_tbl)
               begin
                  // First cycle latches the address and steps the pointer; reads also strobe flash
                  instr_reg    <= wdata_reg[15:0];
                  tbl_addr_reg <= acc_addr;
                  state_reg    <= ST_TBL2;
                  if (!is_tbl_wr)
                  begin
                     PM_RD_OUT        <= 1'b1;
                     PM_WORD_ADDR_OUT <= acc_addr[PW-1:1];
                  end
               end
               else if (issue && is_tstz && fdata == 8'h00)
               begin
                  // Next instruction is thrown away as a no-op
                  state_reg       <= two_word_reg ? ST_SKIP2 : ST_SKIP;
                  SKIP_ACTIVE_OUT <= 1'b1;
               end
            end
            ST_TBL2:   state_reg <= ST_IDLE;
            ST_SKIP2:  state_reg <= ST_SKIP;
            ST_SKIP:
            begin
               state_reg       <= ST_IDLE;
               SKIP_ACTIVE_OUT <= 1'b0;
            end
            default:   state_reg <= ST_IDLE;
         endcase
      end
   end

   // Table pointer, latch and holding registers
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         ptr_reg   <= PTR_RST;
         latch_reg <= 8'h00;
         for (int i = 0; i < HOLD_N; i++)
            hold_reg[i] <= HOLD_RST;
      end
      else if (issue && is_tbl)
         ptr_reg <= ptr_after;
      else if (state_reg == ST_TBL2)
      begin
         if (instr_reg[2])
            // Only the holding bank changes, never flash
            hold_reg[tbl_addr_reg[HOLD_SEL_W-1:0]] <= latch_reg;
         else
            latch_reg <= tbl_addr_reg[0] ? PM_WORD_IN[15:8]
                                         : PM_WORD_IN[7:0];
      end
      else if (wr_fire && awaddr_reg == OFS_PTR)
         ptr_reg <= wdata_reg[PW-1:0];
      else if (wr_fire && awaddr_reg == OFS_LATCH)
         latch_reg <= wdata_reg[7:0];
   end

   // Work register and flags
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         accum_reg <= ACCUM_RST;
         flags_reg <= '0;
      end
      else if (issue && (is_xorlit || is_xorfile))
      begin
         if (is_xorlit || !wdata_reg[9])
            accum_reg <= xres;
         flags_reg.neg  <= xres[7];
         flags_reg.zero <= xres == 8'h00;
      end
      else if (wr_fire && awaddr_reg == OFS_ACCUM)
         accum_reg <= wdata_reg[7:0];
   end

   // Configuration registers
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         bank_reg     <= 4'h0;
         ext_en_reg   <= 1'b0;
         two_word_reg <= 1'b0;
      end
      else if (wr_fire && awaddr_reg == OFS_BANK)
         bank_reg <= wdata_reg[3:0];
      else if (wr_fire && awaddr_reg == OFS_CFG)
         ext_en_reg <= wdata_reg[0];
      else if (wr_fire && awaddr_reg == OFS_NEXTW)
         two_word_reg <= wdata_reg[0];
   end

   // AXI write channels, either order
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg  <= 32'h00000000;
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end
      else
      begin
         if (AXI_REQ_IN.awvalid && !aw_got_reg)
         begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= {AXI_REQ_IN.awaddr[7:2], 2'b00};
         end
         if (AXI_REQ_IN.wvalid && !w_got_reg)
         begin
            w_got_reg <= 1'b1;
            wdata_reg <= AXI_REQ_IN.wdata;
         end
         if (wr_fire)
         begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            // Busy core refuses new instructions
            bresp_reg  <= (wr_hit && !(awaddr_reg == OFS_INSTR
                          && state_reg != ST_IDLE)) ? RESP_OKAY
                                                    : RESP_SLVERR;
         end
         // Pending until the master takes the visible response
         else if (AXI_RSP_OUT.bvalid && AXI_REQ_IN.bready)
            bvalid_reg <= 1'b0;
      end
   end

   // AXI read channel
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= RESP_OKAY;
      end
      else if (AXI_REQ_IN.arvalid && !rvalid_reg)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= 32'h00000000;
         case ({AXI_REQ_IN.araddr[7:2], 2'b00})
            OFS_ACCUM: rdata_reg[7:0] <= accum_reg;
            OFS_PTR:   rdata_reg[PW-1:0] <= ptr_reg;
            OFS_LATCH: rdata_reg[7:0] <= latch_reg;
            OFS_BANK:  rdata_reg[3:0] <= bank_reg;
            OFS_STAT:  rdata_reg[2:0] <= {state_reg != ST_IDLE,
                                          flags_reg.neg, flags_reg.zero};
            OFS_CFG:   rdata_reg[0] <= ext_en_reg;
            OFS_NEXTW: rdata_reg[0] <= two_word_reg;
            OFS_INSTR: rdata_reg[15:0] <= instr_reg;
            default:
            begin
               if (AXI_REQ_IN.araddr[7:5] == 3'h1)
                  rdata_reg[7:0] <= hold_reg[AXI_REQ_IN.araddr[4:2]];
               else
                  rresp_reg <= RESP_SLVERR;
            end
         endcase
      end
      else if (AXI_RSP_OUT.rvalid && AXI_REQ_IN.rready)
         rvalid_reg <= 1'b0;
   end

   // Ready lines pulse the cycle each item is taken
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
         AXI_RSP_OUT <= '0;
      else
      begin
         AXI_RSP_OUT.awready <= AXI_REQ_IN.awvalid && !aw_got_reg
                                && !AXI_RSP_OUT.awready;
         AXI_RSP_OUT.wready  <= AXI_REQ_IN.wvalid && !w_got_reg
                                && !AXI_RSP_OUT.wready;
         AXI_RSP_OUT.arready <= AXI_REQ_IN.arvalid && !rvalid_reg
                                && !AXI_RSP_OUT.arready;
         // Response stands until the handshake edge, then drops
         AXI_RSP_OUT.bvalid  <= bvalid_reg
                                && !(AXI_RSP_OUT.bvalid && AXI_REQ_IN.bready);
         AXI_RSP_OUT.bresp   <= bresp_reg;
         AXI_RSP_OUT.rvalid  <= rvalid_reg
                                && !(AXI_RSP_OUT.rvalid && AXI_REQ_IN.rready);
         AXI_RSP_OUT.rdata   <= rdata_reg;
         AXI_RSP_OUT.rresp   <= rresp_reg;
      end
   end
endmodule : tax_core

// [core/tax_dmem.sv]
// Small data memory with one read and one write port
module tax_dmem
   import tax_pkg::*;
#(
   parameter int AW = ADDR_W
)(
   input  wire logic          clk_in,
   input  wire logic          rst_in,
   input  wire logic [AW-1:0] raddr_in,
   output logic [7:0]         rdata_out,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [7:0]    wdata_in
);
   logic [7:0] mem [0:(1<<AW)-1];  // File registers, cleared on reset
   // Asynchronous read keeps instructions single-cycle
   assign rdata_out = mem[raddr_in];

   // Write port; reset clears every byte so file reads are never unknown,
   // traded against a reset path on the whole array
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < (1 << AW); i++)
            mem[i] <= 8'h00;
      end
      else if (we_in)
         mem[waddr_in] <= wdata_in;
   end
endmodule : tax_dmem

// [core/tax_pkg.sv]
package tax_pkg;
   // Widths of the core datapath
   localparam int PTR_W      = 21;           // Table byte pointer width
   localparam int HOLD_N     = 8;            // Number of holding registers
   localparam int HOLD_SEL_W = 3;            // Holding register select bits
   localparam int ADDR_W     = 12;           // Data-space address width

   // Register bus offsets (byte addresses)
   localparam logic [7:0] OFS_INSTR  = 8'h00;  // Instruction word, write
   localparam logic [7:0] OFS_NEXTW  = 8'h04;  // Next-word two-word flag
   localparam logic [7:0] OFS_ACCUM  = 8'h08;  // Work register
   localparam logic [7:0] OFS_PTR    = 8'h0C;  // Table byte pointer
   localparam logic [7:0] OFS_LATCH  = 8'h10;  // Table data latch
   localparam logic [7:0] OFS_BANK   = 8'h14;  // Bank select pointer
   localparam logic [7:0] OFS_STAT   = 8'h18;  // Flags and busy, read
   localparam logic [7:0] OFS_CFG    = 8'h1C;  // Extended set enable
   localparam logic [7:0] OFS_HOLD0  = 8'h20;  // Holding registers 0..7

   // Reset values
   localparam logic [7:0]       ACCUM_RST = 8'h00;
   localparam logic [PTR_W-1:0] PTR_RST   = 21'h000000;
   localparam logic [7:0]       HOLD_RST  = 8'hFF;  // Erased flash pattern

   // Opcode fields
   localparam logic [13:0] OP_TBL_HI   = 14'h0002;  // 0000 0000 0000 10xx
   localparam logic [7:0]  OP_XORLIT   = 8'h0A;     // 0000 1010
   localparam logic [5:0]  OP_XORFILE  = 6'h06;     // 0001 10xx
   localparam logic [6:0]  OP_TSTZ     = 7'h33;     // 0110 011x
   localparam logic [7:0]  IDX_LIMIT   = 8'h5F;     // Indexed mode threshold
   localparam logic [7:0]  ACCESS_HI   = 8'h60;     // Upper access half base

   // Pointer update modes
   typedef enum logic [1:0] {
      TAX_NONE = 2'h0,
      TAX_POST_INC = 2'h1,
      TAX_POST_DEC = 2'h2,
      TAX_PRE_INC = 2'h3
   } tax_ptr_mode_t;

   // Flags driven from result
   typedef struct packed {
      logic neg;
      logic zero;
   } tax_flags_t;

   // AXI4-Lite bundles
   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } tax_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } tax_axi_rsp_t;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : tax_pkg

// [core/tax_ptr_step.sv]
// Pointer arithmetic for the four table update modes
module tax_ptr_step
   import tax_pkg::*;
#(
   parameter int W = PTR_W
)(
   input  wire logic [W-1:0] ptr_in,
   input  wire logic [1:0]   mode_in,
   output logic [W-1:0]      access_out,
   output logic [W-1:0]      final_out
);
   logic [W-1:0] inc;  // Pointer plus one, wraps in range
   logic [W-1:0] dec;  // Pointer minus one
   assign inc = ptr_in + {{(W-1){1'b0}}, 1'b1};
   assign dec = ptr_in - {{(W-1){1'b0}}, 1'b1};

   // Access address and value left behind
   always_comb
   begin
      access_out = ptr_in;
      final_out  = ptr_in;
      case (tax_ptr_mode_t'(mode_in))
         TAX_NONE:     final_out = ptr_in;
         TAX_POST_INC: final_out = inc;
         TAX_POST_DEC: final_out = dec;
         TAX_PRE_INC:
         begin
            // Increment lands before the access
            access_out = inc;
            final_out  = inc;
         end
         default:      final_out = ptr_in;
      endcase
   end
endmodule : tax_ptr_step

// [sim/table_access_xor_skip_exec_bench.sv]
module table_access_xor_skip_exec_bench
   import tax_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic         clock;     // 25 MHz core clock
   logic         rst;       // Synchronous reset
   tax_axi_req_t req;       // Bus master side
   tax_axi_rsp_t rsp;       // Bus slave side
   logic [19:0]  pm_addr;   // Program word address
   logic         pm_rd;     // Program read strobe
   logic [15:0]  pm_word;   // Program word back
   logic         skip;      // Skip cycles flag
   int           err_count;
   int           total_checks;
   int           cyc;       // Timeout counter
   int           rd_count;  // Program read strobes seen
   int           skip_count; // Skip cycles seen

   tax_core #(.PW(PTR_W)) tax_core_i (
      .CLOCK_IN(clock), .RST_IN(rst), .AXI_REQ_IN(req), .AXI_RSP_OUT(rsp),
      .PM_WORD_ADDR_OUT(pm_addr), .PM_RD_OUT(pm_rd), .PM_WORD_IN(pm_word),
      .INDEX_BASE_IN(12'h100), .SKIP_ACTIVE_OUT(skip));
   tax_pmem_model tax_pmem_model_i (
      .addr_in(pm_addr), .rd_in(pm_rd), .word_out(pm_word));

   always #20 clock = ~clock;

   // Count strobes, and cut a hang short
   always @(posedge clock)
   begin
      rd_count += int'(pm_rd === 1'b1);
      skip_count += int'(skip === 1'b1);
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk_resp

   // Address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      @(posedge clock);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do
      begin
         @(posedge clock);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end
      while (rsp.bvalid !== 1'b1);
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge clock);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do
      begin
         @(posedge clock);
         if (rsp.arready) req.arvalid <= 1'b0;
      end
      while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask : axi_rd

   // Issue one instruction and wait for busy to clear
   task automatic exec(input logic [15:0] op);
      logic [31:0] d;
      logic [1:0]  r;
      axi_wr(OFS_INSTR, {16'h0000, op}, r);
      chk_resp(r, RESP_OKAY);
      do
         axi_rd(OFS_STAT, d, r);
      while (d[2] !== 1'b0);
   endtask : exec

   // Expected byte: model pattern, pointer bit 0 picks the half
   function automatic logic [7:0] pm_byte(input logic [20:0] p);
      return p[0] ? (p[8:1] ^ 8'hC3) : (p[8:1] ^ p[20:13]);
   endfunction : pm_byte

   function automatic logic [20:0] ptr_step(input logic [20:0] p,
                                            input logic [1:0] m);
      return (m == 2'h2) ? p - 21'h1 : (m == 2'h0) ? p : p + 21'h1;
   endfunction : ptr_step

   // Reset values, unmapped and read-only places
   task automatic t_bus();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(OFS_ACCUM, d, r);
      chk_val(d, 32'h00000000);
      axi_rd(OFS_PTR, d, r);
      chk_val(d, 32'h00000000);
      axi_rd(OFS_CFG, d, r);
      chk_val(d, 32'h00000000);
      axi_rd(8'h40, d, r);
      chk_resp(r, RESP_SLVERR);
      axi_wr(8'h44, 32'h0000005A, r);
      chk_resp(r, RESP_SLVERR);
      axi_wr(OFS_HOLD0, 32'h00000012, r);
      axi_rd(OFS_HOLD0, d, r);
      chk_val(d, 32'h000000FF);
      axi_wr(OFS_CFG, 32'h00000001, r);
      axi_rd(OFS_CFG, d, r);
      chk_val(d, 32'h00000001);
      axi_wr(OFS_CFG, 32'h00000000, r);
      $display("test bus done");
   endtask : t_bus

   // All four read modes, at a plain and a wrapping pointer
   task automatic t_table_read();
      logic [20:0] p;
      logic [31:0] d;
      logic [1:0]  r;
      int          n0;
      axi_wr(OFS_ACCUM, 32'h00000080, r);
      exec({OP_XORLIT, 8'h00});
      n0 = rd_count;
      for (int i = 0; i < 8; i++)
      begin
         p = i[2] ? 21'h1FFFFF : 21'h00A356;
         axi_wr(OFS_PTR, {11'h000, p}, r);
         exec({OP_TBL_HI, i[1:0]});
         axi_rd(OFS_LATCH, d, r);
         chk_val(d, {24'h0, pm_byte(i[1:0] == 2'h3 ? p + 21'h1 : p)});
         axi_rd(OFS_PTR, d, r);
         chk_val(d, {11'h000, ptr_step(p, i[1:0])});
      end
      chk_val(rd_count - n0, 32'd8);
      axi_rd(OFS_STAT, d, r);
      chk_val(d, 32'h00000002);
      $display("test table_read done");
   endtask : t_table_read

   // All four write modes; only holding registers change
   task automatic t_table_write();
      logic [20:0] p;
      logic [20:0] a;
      logic [31:0] d;
      logic [1:0]  r;
      int          n0;
      n0 = rd_count;
      for (int i = 0; i < 4; i++)
      begin
         p = 21'h01389A;
         a = (i == 3) ? p + 21'h1 : p;
         axi_wr(OFS_LATCH, 32'h30 + i, r);
         axi_wr(OFS_PTR, {11'h000, p}, r);
         exec({14'h0003, i[1:0]});
         axi_rd(OFS_HOLD0 + {3'h0, a[2:0], 2'h0}, d, r);
         chk_val(d, 32'h30 + i);
         axi_rd(OFS_PTR, d, r);
         chk_val(d, {11'h000, ptr_step(p, i[1:0])});
      end
      axi_rd(OFS_HOLD0 + 8'h1C, d, r);
      chk_val(d, 32'h000000FF);
      chk_val(rd_count - n0, 32'd0);
      $display("test table_write done");
   endtask : t_table_write

   // Literal xor chain through clear, negative and plain results
   task automatic t_xor_literal();
      logic [7:0]  k [4] = '{8'hAF, 8'h1A, 8'h80, 8'hFF};
      logic [7:0]  w;
      logic [31:0] d;
      logic [1:0]  r;
      w = 8'hB5;
      axi_wr(OFS_ACCUM, {24'h0, w}, r);
      for (int i = 0; i < 4; i++)
      begin
         w = w ^ k[i];
         exec({OP_XORLIT, k[i]});
         axi_rd(OFS_ACCUM, d, r);
         chk_val(d, {24'h0, w});
         axi_rd(OFS_STAT, d, r);
         chk_val(d, {30'h0, w[7], w == 8'h00});
      end
      $display("test xor_literal done");
   endtask : t_xor_literal

   // File xor, banked and indexed addressing, zero test skips
   task automatic t_file();
      logic [31:0] d;
      logic [1:0]  r;
      int          n0;
      n0 = skip_count;
      axi_wr(OFS_BANK, 32'h00000003, r);
      axi_wr(OFS_ACCUM, 32'h000000B5, r);
      exec(16'h1B45); // B5 into 345h
      axi_wr(OFS_ACCUM, 32'h000000AF, r);
      exec(16'h1945);
      axi_rd(OFS_ACCUM, d, r);
      chk_val(d, 32'h0000001A);
      axi_wr(OFS_CFG, 32'h00000001, r);
      exec(16'h1A05); // 1A into indexed 105h
      axi_wr(OFS_CFG, 32'h00000000, r);
      axi_wr(OFS_BANK, 32'h00000001, r);
      exec(16'h6705);
      chk_val(skip_count - n0, 32'd0);
      exec(16'h6605);
      chk_val(skip_count - n0, 32'd1);
      axi_wr(OFS_NEXTW, 32'h00000001, r);
      exec(16'h6745);
      chk_val(skip_count - n0, 32'd3);
      axi_rd(OFS_STAT, d, r);
      chk_val(d, 32'h00000000);
      $display("test file done");
   endtask : t_file

   initial
   begin
      clock = 1'b0;
      rst = 1'b1;
      req = '0;
      err_count = 0;
      total_checks = 0;
      cyc = 0;
      rd_count = 0;
      skip_count = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      t_bus();
      t_table_read();
      t_table_write();
      t_xor_literal();
      t_file();
      results();
   end
endmodule : table_access_xor_skip_exec_bench

// [sim/tax_core_props.sv]
module tax_core_props
   import tax_pkg::*;
#(
   parameter int PW = PTR_W
)(
   input wire logic          CLOCK_IN,
   input wire logic          RST_IN,
   input wire tax_axi_req_t  AXI_REQ_IN,
   input wire tax_axi_rsp_t  AXI_RSP_OUT,
   input wire logic [PW-2:0] PM_WORD_ADDR_OUT,
   input wire logic          PM_RD_OUT,
   input wire logic [15:0]   PM_WORD_IN,
   input wire logic [11:0]   INDEX_BASE_IN,
   input wire logic          SKIP_ACTIVE_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (RST_IN);

   logic       aw_bad_reg;   // Last write address outside the map
   logic       ar_bad_reg;   // Last read address outside the map
   logic [3:0] since_rd_reg; // Cycles since a table read opcode went in

   // Class of the write address, kept until the response
   always_ff @(posedge CLOCK_IN)
   begin
      if (AXI_REQ_IN.awvalid && AXI_RSP_OUT.awready)
         aw_bad_reg <= (AXI_REQ_IN.awaddr > 8'h3C)
                       || (AXI_REQ_IN.awaddr[1:0] != 2'h0);
   end

   // Class of the read address, kept until the data
   always_ff @(posedge CLOCK_IN)
   begin
      if (AXI_REQ_IN.arvalid && AXI_RSP_OUT.arready)
         ar_bad_reg <= (AXI_REQ_IN.araddr > 8'h3C)
                       || (AXI_REQ_IN.araddr[1:0] != 2'h0);
   end

   // Saturating age counter; saturation avoids wrap back into range
   always_ff @(posedge CLOCK_IN)
   begin
      if (RST_IN)
         since_rd_reg <= 4'hF;
      else if (AXI_REQ_IN.wvalid && AXI_RSP_OUT.wready
               && AXI_REQ_IN.wdata[15:2] == OP_TBL_HI)
         since_rd_reg <= 4'h0;
      else if (since_rd_reg != 4'hF)
         since_rd_reg <= since_rd_reg + 4'h1;
   end

   a_rd_one_pulse: assert property (PM_RD_OUT |=> !PM_RD_OUT)
      else $error("memory read strobe longer than one cycle");
   a_rd_has_cause: assert property (PM_RD_OUT |-> since_rd_reg < 4'hC)
      else $error("memory read without a table read opcode");
   a_skip_short: assert property
      ($rose(SKIP_ACTIVE_OUT) |-> ##[1:2] !SKIP_ACTIVE_OUT)
      else $error("skip lasted more than two cycles");
   a_reset_quiet: assert property ($fell(RST_IN) |->
      !PM_RD_OUT && !SKIP_ACTIVE_OUT
      && !AXI_RSP_OUT.bvalid && !AXI_RSP_OUT.rvalid)
      else $error("outputs active right after reset");
   a_wr_bad_err: assert property
      (AXI_RSP_OUT.bvalid && aw_bad_reg |-> AXI_RSP_OUT.bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   a_rd_bad_err: assert property
      (AXI_RSP_OUT.rvalid && ar_bad_reg |-> AXI_RSP_OUT.rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
   a_bresp_once: assert property
      (AXI_RSP_OUT.bvalid && AXI_REQ_IN.bready |=> !AXI_RSP_OUT.bvalid)
      else $error("write response repeated");
   a_rresp_once: assert property
      (AXI_RSP_OUT.rvalid && AXI_REQ_IN.rready |=> !AXI_RSP_OUT.rvalid)
      else $error("read response repeated");

   c_mem_read: cover property (PM_RD_OUT);
   c_wr_refused: cover property
      (AXI_RSP_OUT.bvalid && AXI_RSP_OUT.bresp == RESP_SLVERR);
   c_rd_ok: cover property
      (AXI_RSP_OUT.rvalid && AXI_RSP_OUT.rresp == RESP_OKAY);
endmodule : tax_core_props

bind tax_core tax_core_props #(.PW(PW)) tax_core_props_i (
   .CLOCK_IN         (CLOCK_IN),
   .RST_IN           (RST_IN),
   .AXI_REQ_IN       (AXI_REQ_IN),
   .AXI_RSP_OUT      (AXI_RSP_OUT),
   .PM_WORD_ADDR_OUT (PM_WORD_ADDR_OUT),
   .PM_RD_OUT        (PM_RD_OUT),
   .PM_WORD_IN       (PM_WORD_IN),
   .INDEX_BASE_IN    (INDEX_BASE_IN),
   .SKIP_ACTIVE_OUT  (SKIP_ACTIVE_OUT)
);

// [sim/tax_pmem_model.sv]
// Program flash model: word stands while strobe high, garbage otherwise
module tax_pmem_model
   import tax_pkg::*;
(
   input  wire logic [19:0] addr_in,
   input  wire logic        rd_in,
   output logic [15:0]      word_out
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] pat;  // Word pattern at this address

   // Core samples the word at the edge that ends its strobe
   assign pat      = {addr_in[7:0] ^ 8'hC3, addr_in[7:0] ^ addr_in[19:12]};
   assign word_out = rd_in ? pat : ~pat; // Stale data never looks valid
endmodule : tax_pmem_model
